/* File: rtl/cpu_regs.sv */
`include "cpu_regs_consts.svh"

module cpu_regs
  import cpu_regs_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire cpu_op_t     op_i,
  input  wire logic [7:0]  imm_i,
  input  wire logic [7:0]  acc_i,
  input  wire logic [15:0] load_val_i,
  input  wire logic        fetch_i,
  input  wire logic        flow_load_i,
  input  wire logic [15:0] flow_addr_i,
  input  wire logic        bit_c_we_i,
  input  wire logic        bit_c_i,
  input  wire logic        boundary_i,
  input  wire logic        irq_req_i,
  input  wire logic        irq_stacked_i,
  input  wire logic        vec_valid_i,
  input  wire logic [7:0]  vec_data_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic [7:0]       reg_rdata_o,
  output logic [15:0]      vec_addr_o,
  output logic             vec_req_o,
  output logic             running_o,
  output logic             irq_take_o,
  output logic [15:0]      idx_addr_o,
  output logic [15:0]      sp_o,
  output logic [15:0]      pc_o,
  output logic [7:0]       flags_o,
  output logic [7:0]       acc_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  cpu_regs_state_t q_ff;
  cpu_regs_state_t nxt_q;
  logic [8:0]      sum;
  logic [4:0]      half;
  logic [7:0]      res;
  logic [7:0]      corr;
  logic            res_we;
  logic            cin;
  logic [7:0]      b;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_q  = q_ff;
    res    = q_ff.idx_lo;
    res_we = 1'b0;
    cin    = 1'b0;
    b      = imm_i;
    sum    = 9'h000;
    half   = 5'h00;
    corr   = 8'h00;
    nxt_q.rdata = 8'h00;
    case (q_ff.state)
      ST_VEC_HI: begin
        if (vec_valid_i) begin
          nxt_q.pc[15:8] = vec_data_i;
          nxt_q.state    = ST_VEC_LO;
        end
      end
      ST_VEC_LO: begin
        if (vec_valid_i) begin
          nxt_q.pc[7:0] = vec_data_i;
          nxt_q.state   = ST_RUN;
        end
      end
      ST_RUN: begin
        if (flow_load_i) begin
          nxt_q.pc = flow_addr_i;
        end else if (fetch_i) begin
          nxt_q.pc = q_ff.pc + 16'h0001;
        end
        case (op_i)
          OP_LO_CLR: begin
            res = 8'h00;
            res_we = 1'b1;
            nxt_q.flags[`FLG_V] = 1'b0;
            nxt_q.flags[`FLG_C] = 1'b0;
          end
          OP_LO_INC: begin
            res = q_ff.idx_lo + 8'h01;
            res_we = 1'b1;
            nxt_q.flags[`FLG_V] = (q_ff.idx_lo == 8'h7f);
          end
          OP_LO_DEC: begin
            res = q_ff.idx_lo - 8'h01;
            res_we = 1'b1;
            nxt_q.flags[`FLG_V] = (q_ff.idx_lo == 8'h80);
          end
          OP_LO_COM: begin
            res = ~q_ff.idx_lo;
            res_we = 1'b1;
            nxt_q.flags[`FLG_V] = 1'b0;
            nxt_q.flags[`FLG_C] = 1'b1;
          end
          OP_LO_NEG: begin
            res = 8'h00 - q_ff.idx_lo;
            res_we = 1'b1;
            nxt_q.flags[`FLG_V] = (q_ff.idx_lo == 8'h80);
            nxt_q.flags[`FLG_C] = (q_ff.idx_lo != 8'h00);
          end
          OP_LO_ASL, OP_LO_ROL: begin
            cin = (op_i == OP_LO_ROL) ? q_ff.flags[`FLG_C] : 1'b0;
            res = {q_ff.idx_lo[6:0], cin};
            res_we = 1'b1;
            nxt_q.flags[`FLG_C] = q_ff.idx_lo[7];
            nxt_q.flags[`FLG_V] = q_ff.idx_lo[7] ^ q_ff.idx_lo[6];
          end
          OP_LO_LSR, OP_LO_ASR, OP_LO_ROR: begin
            cin = (op_i == OP_LO_ROR) ? q_ff.flags[`FLG_C] :
                  (op_i == OP_LO_ASR) ? q_ff.idx_lo[7] : 1'b0;
            res = {cin, q_ff.idx_lo[7:1]};
            res_we = 1'b1;
            nxt_q.flags[`FLG_C] = q_ff.idx_lo[0];
            nxt_q.flags[`FLG_V] = cin ^ q_ff.idx_lo[0];
          end
          OP_ACC_TO_LO: begin
            nxt_q.idx_lo = acc_i;
          end
          OP_LO_TO_ACC: begin
            nxt_q.acc = q_ff.idx_lo;
          end
          OP_IDX_INC: begin
            {nxt_q.idx_hi, nxt_q.idx_lo} = {q_ff.idx_hi, q_ff.idx_lo} + 16'h0001;
          end
          OP_STACK_ADJUST: begin
            nxt_q.sp = q_ff.sp + {{8{imm_i[7]}}, imm_i};
          end
          OP_STACK_LOW_RESET: begin
            nxt_q.sp[7:0] = 8'(`SP_RESET);
          end
          OP_ADD, OP_ADC, OP_SUB: begin
            cin = (op_i == OP_ADC) & q_ff.flags[`FLG_C];
            if (op_i == OP_SUB) begin
              b   = ~imm_i;
              cin = 1'b1;
            end
            sum  = {1'b0, acc_i} + {1'b0, b} + {8'h00, cin};
            half = {1'b0, acc_i[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            res  = sum[7:0];
            nxt_q.acc = res;
            nxt_q.flags[`FLG_V] = (acc_i[7] == b[7]) && (res[7] != acc_i[7]);
            if (op_i != OP_SUB) begin
              nxt_q.flags[`FLG_H] = half[4];
              nxt_q.flags[`FLG_C] = sum[8];
            end else begin
              nxt_q.flags[`FLG_C] = ~sum[8];
            end
            nxt_q.flags[`FLG_N] = res[7];
            nxt_q.flags[`FLG_Z] = (res == 8'h00);
          end
          OP_DECIMAL_ADJUST: begin
            if (q_ff.flags[`FLG_H] || (acc_i[3:0] > 4'h9)) begin
              corr[3:0] = 4'h6;
            end
            if (q_ff.flags[`FLG_C] || (acc_i > 8'h99)) begin
              corr[7:4] = 4'h6;
            end
            sum = {1'b0, acc_i} + {1'b0, corr};
            res = sum[7:0];
            nxt_q.acc = res;
            nxt_q.flags[`FLG_C] = q_ff.flags[`FLG_C] | corr[7:4] != 4'h0;
            nxt_q.flags[`FLG_N] = res[7];
            nxt_q.flags[`FLG_Z] = (res == 8'h00);
          end
          OP_LOAD8: begin
            nxt_q.flags[`FLG_N] = load_val_i[7];
            nxt_q.flags[`FLG_Z] = (load_val_i[7:0] == 8'h00);
            nxt_q.flags[`FLG_V] = 1'b0;
          end
          OP_LOAD16: begin
            nxt_q.flags[`FLG_N] = load_val_i[15];
            nxt_q.flags[`FLG_Z] = (load_val_i == 16'h0000);
            nxt_q.flags[`FLG_V] = 1'b0;
          end
          OP_MASK_CLEAR: begin
            nxt_q.irq_hold = q_ff.flags[`FLG_I];
            nxt_q.flags[`FLG_I] = 1'b0;
          end
          OP_MASK_SET: begin
            nxt_q.flags[`FLG_I] = 1'b1;
          end
          OP_ACC_TO_FLAGS: begin
            nxt_q.irq_hold = q_ff.flags[`FLG_I] & ~acc_i[`FLG_I];
            nxt_q.flags = acc_i;
          end
          default: begin
          end
        endcase
        if (res_we) begin
          nxt_q.idx_lo = res;
          nxt_q.flags[`FLG_N] = res[7];
          nxt_q.flags[`FLG_Z] = (res == 8'h00);
        end
        if (bit_c_we_i) begin
          nxt_q.flags[`FLG_C] = bit_c_i;
        end
        // Hold only covers one boundary, then expires
        if (boundary_i && (op_i != OP_MASK_CLEAR) && (op_i != OP_ACC_TO_FLAGS)) begin
          nxt_q.irq_hold = 1'b0;
        end
        if (irq_stacked_i) begin
          nxt_q.flags[`FLG_I] = 1'b1;
        end
        // ----------------------------------------
        // Register port writes win over datapath
        // ----------------------------------------
        if (reg_we_i) begin
          case (reg_addr_i)
            `REG_FLAGS:  nxt_q.flags        = reg_wdata_i;
            `REG_IDX_HI: nxt_q.idx_hi       = reg_wdata_i;
            `REG_IDX_LO: nxt_q.idx_lo       = reg_wdata_i;
            `REG_SP_HI:  nxt_q.sp[15:8]     = reg_wdata_i;
            `REG_SP_LO:  nxt_q.sp[7:0]      = reg_wdata_i;
            default: begin
            end
          endcase
        end
      end
      default: begin
        nxt_q.state = ST_VEC_HI;
      end
    endcase
    nxt_q.flags = nxt_q.flags | `FLG_FIXED_MASK;
    if (reg_re_i) begin
      case (reg_addr_i)
        `REG_FLAGS:  nxt_q.rdata = q_ff.flags;
        `REG_IDX_HI: nxt_q.rdata = q_ff.idx_hi;
        `REG_IDX_LO: nxt_q.rdata = q_ff.idx_lo;
        `REG_SP_HI:  nxt_q.rdata = q_ff.sp[15:8];
        `REG_SP_LO:  nxt_q.rdata = q_ff.sp[7:0];
        `REG_PC_HI:  nxt_q.rdata = q_ff.pc[15:8];
        `REG_PC_LO:  nxt_q.rdata = q_ff.pc[7:0];
        `REG_STATUS: nxt_q.rdata = {6'h00, q_ff.irq_hold, q_ff.state == ST_RUN};
        default:     nxt_q.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Low index byte and acc keep their value through reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff.state    <= ST_VEC_HI;
      q_ff.idx_hi   <= `HI_RESET;
      q_ff.sp       <= `SP_RESET;
      q_ff.pc       <= 16'h0000;
      q_ff.flags    <= `FLAGS_RESET;
      q_ff.irq_hold <= 1'b0;
      q_ff.rdata    <= 8'h00;
    end else begin
      q_ff.state    <= nxt_q.state;
      q_ff.idx_hi   <= nxt_q.idx_hi;
      q_ff.sp       <= nxt_q.sp;
      q_ff.pc       <= nxt_q.pc;
      q_ff.flags    <= nxt_q.flags;
      q_ff.irq_hold <= nxt_q.irq_hold;
      q_ff.rdata    <= nxt_q.rdata;
      q_ff.idx_lo   <= nxt_q.idx_lo;
      q_ff.acc      <= nxt_q.acc;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata_o = q_ff.rdata;
  assign vec_req_o   = (q_ff.state != ST_RUN);
  assign vec_addr_o  = (q_ff.state == ST_VEC_LO) ? `VEC_LO_ADDR : `VEC_HI_ADDR;
  assign running_o   = (q_ff.state == ST_RUN);
  assign irq_take_o  = irq_req_i & boundary_i & running_o &
                       ~q_ff.flags[`FLG_I] & ~q_ff.irq_hold;
  assign idx_addr_o  = {q_ff.idx_hi, q_ff.idx_lo};
  assign sp_o        = q_ff.sp;
  assign pc_o        = q_ff.pc;
  assign flags_o     = q_ff.flags;
  assign acc_o       = q_ff.acc;

endmodule : cpu_regs

/* File: rtl/cpu_regs_consts.svh */
`ifndef CPU_REGS_CONSTS_SVH
`define CPU_REGS_CONSTS_SVH

// ----------------------------------------
// Reset values and vector fetch addresses
// ----------------------------------------
`define HI_RESET       8'h00
`define SP_RESET       16'h00ff
`define FLAGS_RESET    8'h68
`define VEC_HI_ADDR    16'hfffe
`define VEC_LO_ADDR    16'hffff

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define FLG_V          7
`define FLG_ONE6       6
`define FLG_ONE5       5
`define FLG_H          4
`define FLG_I          3
`define FLG_N          2
`define FLG_Z          1
`define FLG_C          0
`define FLG_FIXED_MASK 8'h60

// ----------------------------------------
// Register port offsets
// ----------------------------------------
`define REG_FLAGS      4'h0
`define REG_IDX_HI     4'h1
`define REG_IDX_LO     4'h2
`define REG_SP_HI      4'h3
`define REG_SP_LO      4'h4
`define REG_PC_HI      4'h5
`define REG_PC_LO      4'h6
`define REG_STATUS     4'h7

`endif

/* File: rtl/cpu_regs_pkg.sv */
package cpu_regs_pkg;

  // Micro-operations issued by the execution datapath
  typedef enum logic [4:0] {
    OP_NONE,
    OP_LO_CLR,
    OP_LO_INC,
    OP_LO_DEC,
    OP_LO_COM,
    OP_LO_NEG,
    OP_LO_ASL,
    OP_LO_LSR,
    OP_LO_ASR,
    OP_LO_ROL,
    OP_LO_ROR,
    OP_ACC_TO_LO,
    OP_LO_TO_ACC,
    OP_IDX_INC,
    OP_STACK_ADJUST,
    OP_STACK_LOW_RESET,
    OP_ADD,
    OP_ADC,
    OP_SUB,
    OP_DECIMAL_ADJUST,
    OP_LOAD8,
    OP_LOAD16,
    OP_MASK_CLEAR,
    OP_MASK_SET,
    OP_ACC_TO_FLAGS
  } cpu_op_t;

  typedef enum logic [1:0] {
    ST_VEC_HI,
    ST_VEC_LO,
    ST_RUN
  } cpu_state_t;

  typedef struct packed {
    cpu_state_t  state;
    logic [7:0]  idx_hi;
    logic [7:0]  idx_lo;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  flags;
    logic [7:0]  acc;
    logic        irq_hold;
    logic [7:0]  rdata;
  } cpu_regs_state_t;

endpackage : cpu_regs_pkg

/* File: dv/cpu_regs_checker.sv */
// ----------------------------------------
// Port checker
// ----------------------------------------
module cpu_regs_checker
  import cpu_regs_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire cpu_op_t     op_i,
  input wire logic [7:0]  imm_i,
  input wire logic        fetch_i,
  input wire logic        flow_load_i,
  input wire logic [15:0] flow_addr_i,
  input wire logic        reg_we_i,
  input wire logic        irq_stacked_i,
  input wire logic        vec_valid_i,
  input wire logic [7:0]  vec_data_i,
  input wire logic [15:0] vec_addr_o,
  input wire logic        vec_req_o,
  input wire logic        running_o,
  input wire logic        irq_take_o,
  input wire logic [15:0] idx_addr_o,
  input wire logic [15:0] sp_o,
  input wire logic [15:0] pc_o,
  input wire logic [7:0]  flags_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // Port writes and stacking outrank ops, so ops are judged only without them
  wire quiet = running_o && !reg_we_i && !irq_stacked_i;

  AST_FIXED_ONES: assert property (flags_o[6:5] == 2'h3)
    else $error("fixed flag bits not one");
  AST_RESET_VAL: assert property (disable iff (1'h0) !rst_n_i ##1 !rst_n_i |->
    sp_o == 16'h00ff && idx_addr_o[15:8] == 8'h00 && flags_o[3])
    else $error("reset values wrong");
  AST_SP_ADJUST: assert property (quiet && op_i == OP_STACK_ADJUST |=>
    sp_o == $past(sp_o) + {{8{$past(imm_i[7])}}, $past(imm_i)})
    else $error("stack adjust sum wrong");
  AST_SP_LOW: assert property (quiet && op_i == OP_STACK_LOW_RESET |=>
    sp_o[15:8] == $past(sp_o[15:8]))
    else $error("stack high byte changed");
  AST_PC_STEP: assert property (quiet && fetch_i && !flow_load_i |=>
    pc_o == $past(pc_o) + 16'h0001)
    else $error("fetch did not step pc");
  AST_PC_FLOW: assert property (quiet && flow_load_i |=> pc_o == $past(flow_addr_i))
    else $error("flow load missed");
  AST_VECTOR: assert property (vec_req_o && vec_addr_o == 16'hfffe && vec_valid_i
    ##1 vec_valid_i |=> running_o && pc_o == {$past(vec_data_i, 2), $past(vec_data_i)})
    else $error("vector load wrong");
  AST_MASK_BLOCK: assert property (irq_take_o |-> !flags_o[3] && running_o)
    else $error("interrupt taken while masked");
  AST_STACK_MASK: assert property (running_o && irq_stacked_i && !reg_we_i |=> flags_o[3])
    else $error("mask not set after stacking");
  AST_CLEAR_HOLD: assert property (quiet && op_i == OP_MASK_CLEAR && flags_o[3] |=>
    !flags_o[3] && !irq_take_o)
    else $error("interrupt right after mask clear");
endmodule // cpu_regs_checker

bind cpu_regs cpu_regs_checker i_chk (
  .clk_sys_i, .rst_n_i, .op_i, .imm_i, .fetch_i, .flow_load_i, .flow_addr_i, .reg_we_i,
  .irq_stacked_i, .vec_valid_i, .vec_data_i, .vec_addr_o, .vec_req_o, .running_o,
  .irq_take_o, .idx_addr_o, .sp_o, .pc_o, .flags_o
);

/* File: dv/tb_cpu_regs.sv */
// ----------------------------------------
// Bench
// ----------------------------------------
module tb_cpu_regs import cpu_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i = 1'h0;
  logic        rst_n_i, fetch_i, flow_load_i, boundary_i, irq_req_i, irq_stacked_i;
  logic        vec_valid_i, reg_we_i, reg_re_i, vec_req_o, running_o, irq_take_o;
  logic        bit_c_we_i, bit_c_i;
  cpu_op_t     op_i;
  logic [7:0]  imm_i, acc_i, vec_data_i, reg_wdata_i, reg_rdata_o, flags_o, acc_o;
  logic [15:0] load_val_i, flow_addr_i, vec_addr_o, idx_addr_o, sp_o, pc_o;
  logic [3:0]  reg_addr_i;
  logic [31:0] seed = 32'h0000005e;
  int          n_fail, cmp_count;
  logic [15:0] e_pc, e_sp = 16'h00ff;
  logic [7:0]  e_hi = 8'h00, e_lo, e_acc, e_fl = 8'h68, fm = 8'h68;
  logic        e_i = 1'h1, e_hold = 1'h0, acc_ok = 1'h0;
  cpu_op_t     ops[20] = '{OP_LO_CLR, OP_LO_INC, OP_LO_DEC, OP_LO_COM, OP_LO_NEG, OP_LO_ASL,
    OP_LO_LSR, OP_LO_ASR, OP_LO_ROL, OP_LO_ROR, OP_ACC_TO_LO, OP_LO_TO_ACC, OP_IDX_INC,
    OP_STACK_ADJUST, OP_STACK_LOW_RESET, OP_ADD, OP_SUB, OP_LOAD8, OP_LOAD16, OP_ACC_TO_FLAGS};

  always #25 clk_sys_i = ~clk_sys_i;

  cpu_regs i_dut (.clk_sys_i, .rst_n_i, .op_i, .imm_i, .acc_i, .load_val_i, .fetch_i,
    .flow_load_i, .flow_addr_i, .bit_c_we_i, .bit_c_i, .boundary_i, .irq_req_i,
    .irq_stacked_i, .vec_valid_i, .vec_data_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
    .reg_re_i, .reg_rdata_o, .vec_addr_o, .vec_req_o, .running_o, .irq_take_o, .idx_addr_o,
    .sp_o, .pc_o, .flags_o, .acc_o);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic idle();
    op_i <= OP_NONE;
    {fetch_i, flow_load_i, boundary_i, irq_req_i, irq_stacked_i, bit_c_we_i} <= 6'h00;
  endtask

  // Read compares the byte in the one cycle it stands
  task automatic port(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    idle();
    {reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i} <= {w, ~w, a, d};
    @(posedge clk_sys_i);
    {reg_we_i, reg_re_i} <= 2'h0;
    #1 if (!w) chk(reg_rdata_o, d);
  endtask

  task automatic step(input cpu_op_t o, input logic [2:0] b);
    logic [31:0] x, y;
    logic [8:0]  s;
    logic [4:0]  hs;
    logic [7:0]  a, m, r;
    logic        fl, cin, bw;
    x = rnd();
    y = rnd();
    a = x[7:0];
    m = x[15:8];
    fl = y[17] & y[18];
    bw = y[19] & y[20];
    @(posedge clk_sys_i);
    op_i <= o;
    {acc_i, imm_i, load_val_i} <= {a, m, x[31:16]};
    {fetch_i, flow_load_i, flow_addr_i} <= {y[16], fl, y[15:0]};
    {irq_stacked_i, boundary_i, irq_req_i} <= b;
    {bit_c_we_i, bit_c_i} <= {bw, y[21]};
    #1;
    e_fl[3] = e_i;
    chk(pc_o, e_pc);
    chk(sp_o, e_sp);
    chk(idx_addr_o, {e_hi, e_lo});
    chk(flags_o & fm, e_fl & fm);
    if (acc_ok) chk(acc_o, e_acc);
    chk(irq_take_o, b[1] & b[0] & ~e_i & ~e_hold);
    e_pc = fl ? y[15:0] : e_pc + {15'h0000, y[16]};
    fm = 8'h68;
    if (b[1] && o != OP_MASK_CLEAR) e_hold = 1'h0;
    case (o)
      OP_LO_CLR: {e_fl[0], e_lo} = 9'h000;
      OP_LO_INC: e_lo = e_lo + 8'h01;
      OP_LO_DEC: e_lo = e_lo - 8'h01;
      OP_LO_COM: {e_fl[0], e_lo} = {1'h1, ~e_lo};
      OP_LO_NEG: {e_fl[0], e_lo} = {e_lo != 8'h00, 8'h00 - e_lo};
      OP_LO_ASL, OP_LO_ROL: {e_fl[0], e_lo} = {e_lo, (o == OP_LO_ROL) & e_fl[0]};
      OP_LO_LSR, OP_LO_ASR, OP_LO_ROR:
        {e_lo, e_fl[0]} = {(o == OP_LO_ROR) ? e_fl[0] : (o == OP_LO_ASR) & e_lo[7], e_lo};
      OP_IDX_INC: {e_hi, e_lo} = {e_hi, e_lo} + 16'h0001;
      OP_ACC_TO_LO: e_lo = a;
      OP_LO_TO_ACC: e_acc = e_lo;
      OP_STACK_ADJUST: e_sp = e_sp + {{8{m[7]}}, m};
      OP_STACK_LOW_RESET: e_sp[7:0] = 8'hff;
      OP_MASK_SET: e_i = 1'h1;
      OP_MASK_CLEAR: begin
        e_hold = e_i;
        e_i = 1'h0;
      end
      OP_ACC_TO_FLAGS: begin
        e_hold = e_i & ~a[3];
        e_i = a[3];
      end
      OP_ADD, OP_ADC, OP_SUB: begin
        cin = (o == OP_ADC) & e_fl[0];
        hs = {1'h0, a[3:0]} + {1'h0, m[3:0]} + {4'h0, cin};
        s = (o == OP_SUB) ? {1'h0, a} - {1'h0, m} : {1'h0, a} + {1'h0, m} + {8'h00, cin};
        e_fl[7] = ((a[7] ^ m[7]) == (o == OP_SUB)) && (s[7] != a[7]);
        {e_fl[4], e_fl[0], e_acc, acc_ok} = {hs[4], s, 1'h1};
        fm = (o == OP_SUB) ? 8'hef : 8'hff;
      end
      OP_DECIMAL_ADJUST: begin
        hs[3:0] = (e_fl[4] || a[3:0] > 4'h9) ? 4'h6 : 4'h0;
        hs[4] = e_fl[0] || a > 8'h99;
        s = {1'h0, a} + {1'h0, hs[4] ? 4'h6 : 4'h0, hs[3:0]};
        {e_fl[0], e_acc, acc_ok} = {e_fl[0] | hs[4], s[7:0], 1'h1};
        fm = 8'hff;
      end
      default: ;
    endcase
    if (o inside {[OP_LO_CLR:OP_LO_ROR]}) fm = 8'h6f;
    r = (o == OP_LOAD8) ? x[23:16] : (fm[7] ? e_acc : e_lo);
    if (o inside {OP_LOAD8, OP_LOAD16}) fm = 8'h6e;
    if (fm[1]) {e_fl[2], e_fl[1]} = {r[7], r == 8'h00};
    if (o == OP_LOAD16) {e_fl[2], e_fl[1]} = {x[31], x[31:16] == 16'h0000};
    if (o == OP_ACC_TO_FLAGS) {e_fl, fm} = {a | 8'h60, 8'hff};
    if (bw) {e_fl[0], fm[0]} = {y[21], 1'h1};
    if (b[2]) e_i = 1'h1;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_fail++;
    summarize();
  end

  initial begin
    logic [31:0] x;
    cpu_op_t     o;
    rst_n_i = 1'h0;
    idle();
    {vec_valid_i, vec_data_i, reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i} <= 23'h000000;
    {imm_i, acc_i, load_val_i, flow_addr_i, bit_c_i} <= 49'h0000000000000;
    repeat (20) @(posedge clk_sys_i);
    chk(sp_o, 16'h00ff);
    chk(idx_addr_o[15:8], 8'h00);
    chk(flags_o, 8'h68);
    chk(vec_addr_o, 16'hfffe);
    rst_n_i <= 1'h1;
    x = rnd();
    @(posedge clk_sys_i);
    {vec_valid_i, vec_data_i} <= {1'h1, x[15:8]};
    @(posedge clk_sys_i);
    vec_data_i <= x[7:0];
    #1 chk(vec_addr_o, 16'hffff);
    @(posedge clk_sys_i);
    vec_valid_i <= 1'h0;
    #1 chk(running_o, 1'h1);
    {e_pc, e_lo} = {x[15:0], x[23:16]};
    port(1'h1, 4'h2, e_lo);
    for (int i = 0; i < 300; i++) begin
      o = ops[rnd() % 20];
      step(o, 3'h0);
      if (o == OP_ADD) begin
        step(OP_ADC, 3'h0);
        step(OP_DECIMAL_ADJUST, 3'h0);
      end
    end
    step(OP_MASK_SET, 3'h3);
    step(OP_MASK_CLEAR, 3'h1);
    step(OP_NONE, 3'h3);
    step(OP_NONE, 3'h3);
    step(OP_NONE, 3'h4);
    step(OP_NONE, 3'h3);
    port(1'h1, 4'h0, 8'h00);
    {e_i, e_fl, fm} = {1'h0, 8'h60, 8'hff};
    port(1'h0, 4'h0, 8'h60);
    port(1'h1, 4'h1, 8'ha5);
    e_hi = 8'ha5;
    port(1'h1, 4'h5, 8'h3c);
    port(1'h1, 4'h3, 8'h12);
    port(1'h1, 4'h4, 8'h5a);
    e_sp = 16'h125a;
    port(1'h0, 4'h1, e_hi);
    port(1'h0, 4'h3, e_sp[15:8]);
    port(1'h0, 4'h4, e_sp[7:0]);
    port(1'h0, 4'h5, e_pc[15:8]);
    port(1'h0, 4'h6, e_pc[7:0]);
    port(1'h0, 4'h2, e_lo);
    port(1'h0, 4'h7, {6'h00, e_hold, 1'h1});
    port(1'h0, 4'h9, 8'h00);
    step(OP_NONE, 3'h0);
    @(posedge clk_sys_i);
    rst_n_i <= 1'h0;
    #1 chk(idx_addr_o, {8'h00, e_lo});
    chk(sp_o, 16'h00ff);
    summarize();
  end
endmodule // tb_cpu_regs
